// ---- src/mbs_pkg.sv ----
package mbs_pkg;

	// ==========================================
	// function and exception codes
	localparam logic [7:0] FC_RD_COIL = 8'h01;
	localparam logic [7:0] FC_RD_DIN = 8'h02;
	localparam logic [7:0] FC_RD_INREG = 8'h04;
	localparam logic [7:0] FC_WR_COIL = 8'h05;
	localparam logic [7:0] FC_WR_COILS = 8'h0F;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;
	localparam logic [7:0] EXC_FLAG = 8'h80;

	// ==========================================
	// ranges and values
	localparam logic [7:0] SLAVE_MIN = 8'h01;
	localparam logic [7:0] SLAVE_MAX = 8'hF7;
	localparam logic [16:0] SPAN_COIL = 17'h0_0004;
	localparam logic [16:0] SPAN_DIN = 17'h0_0008;
	localparam logic [16:0] SPAN_INREG = 17'h0_001C;
	localparam logic [15:0] COIL_ON = 16'hFF00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	localparam logic [7:0] MULTI_BYTES = 8'h01;
	localparam logic [3:0] COILS_RESET = 4'h0;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;

	// ==========================================
	// frame geometry
	localparam int RX_DEPTH = 10;
	localparam logic [3:0] RX_CAP = 4'hB;
	localparam logic [3:0] LEN_STD = 4'h8;
	localparam logic [3:0] LEN_MULTI = 4'hA;
	localparam logic [5:0] LEN_EXC = 6'h03;
	localparam logic [5:0] LEN_BITS = 6'h04;
	localparam logic [5:0] LEN_ECHO = 6'h06;
	localparam logic [5:0] HDR_LEN = 6'h03;

	// ==========================================
	// input register map
	localparam logic [4:0] ADDR_AN_LAST = 5'h0B;
	localparam logic [4:0] ADDR_SUPPLY = 5'h0E;
	localparam logic [4:0] ADDR_TEMP = 5'h18;
	localparam logic [4:0] ADDR_HUMID = 5'h19;
	localparam logic [4:0] ADDR_PULSE_HI = 5'h1A;
	localparam logic [4:0] ADDR_PULSE_LO = 5'h1B;

	// ==========================================
	// types
	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_CRC_LO, ST_CRC_HI} mbs_state_e;

	typedef struct packed {
		logic [5:0][31:0] analog_channel;
		logic [15:0] supply;
		logic [15:0] temperature;
		logic [15:0] humidity;
		logic [31:0] pulse_count;
	} mbs_meas_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic frame_end;
	} mbs_rx_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} mbs_tx_s;

endpackage : mbs_pkg

// ---- src/mbs_crc16.sv ----
`timescale 1ns/1ps
`default_nettype none

module mbs_crc16 (
	// running value
	input wire logic [15:0] crc_in,
	input wire logic [7:0] data,
	output logic [15:0] crc_out
);
	import mbs_pkg::*;

	always_comb begin
		crc_out = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			crc_out = crc_out[0] ? ((crc_out >> 1) ^ CRC_POLY) : (crc_out >> 1);
		end
	end

endmodule : mbs_crc16

`default_nettype wire

// ---- src/mbs_responder.sv ----
`timescale 1ns/1ps
`default_nettype none

module mbs_responder (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// configuration
	input wire logic [7:0] slave_addr,
	// received bytes
	input wire mbs_pkg::mbs_rx_s rx,
	// reply bytes
	output var mbs_pkg::mbs_tx_s tx,
	input wire logic tx_ready,
	// field side
	input wire logic [7:0] din_pins,
	input wire mbs_pkg::mbs_meas_s meas,
	output logic [3:0] relay
);
	import mbs_pkg::*;

	// ==========================================
	// helpers
	function automatic logic [7:0] range_exc(input logic [15:0] st, input logic [15:0] q,
			input logic [16:0] span);
		if (q == 16'h0000 || {1'b0, q} > span)
			return EXC_VALUE;
		if ({1'b0, st} + {1'b0, q} > span)
			return EXC_ADDR;
		return EXC_NONE;
	endfunction : range_exc

	function automatic logic [7:0] bits_read(input logic [7:0] v, input logic [2:0] st,
			input logic [3:0] q);
		logic [8:0] m;
		m = (9'h001 << q) - 9'h001;
		return (v >> st) & m[7:0];
	endfunction : bits_read

	function automatic logic [15:0] reg_word(input mbs_meas_s m, input logic [4:0] a);
		logic [31:0] ch;
		ch = m.analog_channel[a[3:1]];
		if (a <= ADDR_AN_LAST)
			return a[0] ? ch[15:0] : ch[31:16];
		case (a)
			ADDR_SUPPLY: return m.supply;
			ADDR_TEMP: return m.temperature;
			ADDR_HUMID: return m.humidity;
			ADDR_PULSE_HI: return m.pulse_count[31:16];
			ADDR_PULSE_LO: return m.pulse_count[15:0];
			default: return 16'h0000;
		endcase
	endfunction : reg_word

	// ==========================================
	// discrete input synchroniser
	logic [7:0] din_s1_reg, din_s2_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			din_s1_reg <= 8'h00;
			din_s2_reg <= 8'h00;
		end else if (ce) begin
			din_s1_reg <= din_pins;
			din_s2_reg <= din_s1_reg;
		end
	end

	// ==========================================
	// receive collection
	mbs_state_e state_reg, state_next;
	logic [7:0] rx_buf_reg [RX_DEPTH];
	logic [7:0] rx_buf_next [RX_DEPTH];
	logic [3:0] rx_cnt_reg, rx_cnt_next;
	logic [15:0] rx_crc_reg, rx_crc_next, rx_crc_step;

	mbs_crc16 u_rx_crc (
		.crc_in(rx_crc_reg),
		.data(rx.data),
		.crc_out(rx_crc_step)
	);

	always_comb begin
		rx_buf_next = rx_buf_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_crc_next = rx_crc_reg;
		if (rx.frame_end) begin
			rx_cnt_next = 4'h0;
			rx_crc_next = CRC_INIT;
		end else if (rx.valid && state_reg == ST_IDLE) begin
			if (rx_cnt_reg < RX_CAP - 4'h1)
				rx_buf_next[rx_cnt_reg] = rx.data;
			if (rx_cnt_reg != RX_CAP)
				rx_cnt_next = rx_cnt_reg + 4'h1;
			rx_crc_next = rx_crc_step;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_buf_reg <= '{default: 8'h00};
			rx_cnt_reg <= 4'h0;
			rx_crc_reg <= CRC_INIT;
		end else if (ce) begin
			rx_buf_reg <= rx_buf_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_crc_reg <= rx_crc_next;
		end
	end

	// ==========================================
	// request decode
	logic [7:0] fc;
	logic [15:0] req_st, req_q;
	logic frame_ok;
	logic [7:0] exc;
	logic [7:0] dec_hdr [6];
	logic [5:0] dec_len;
	logic dec_regrd;
	logic [3:0] dec_coils;

	assign fc = rx_buf_reg[1];
	assign req_st = {rx_buf_reg[2], rx_buf_reg[3]};
	assign req_q = {rx_buf_reg[4], rx_buf_reg[5]};

	always_comb begin
		frame_ok = rx.frame_end && state_reg == ST_IDLE && rx_crc_reg == 16'h0000
			&& slave_addr >= SLAVE_MIN && slave_addr <= SLAVE_MAX
			&& rx_buf_reg[0] == slave_addr
			&& rx_cnt_reg == ((fc == FC_WR_COILS) ? LEN_MULTI : LEN_STD);
		exc = EXC_NONE;
		dec_hdr = '{slave_addr, fc, rx_buf_reg[2], rx_buf_reg[3], rx_buf_reg[4], rx_buf_reg[5]};
		dec_len = LEN_ECHO;
		dec_regrd = 1'b0;
		dec_coils = relay;
		case (fc)
			FC_RD_COIL: begin
				exc = range_exc(req_st, req_q, SPAN_COIL);
				dec_hdr[2] = 8'h01;
				dec_hdr[3] = bits_read({4'h0, relay}, req_st[2:0], req_q[3:0]);
				dec_len = LEN_BITS;
			end
			FC_RD_DIN: begin
				exc = range_exc(req_st, req_q, SPAN_DIN);
				dec_hdr[2] = 8'h01;
				dec_hdr[3] = bits_read(din_s2_reg, req_st[2:0], req_q[3:0]);
				dec_len = LEN_BITS;
			end
			FC_RD_INREG: begin
				exc = range_exc(req_st, req_q, SPAN_INREG);
				dec_hdr[2] = {req_q[6:0], 1'b0};
				dec_len = HDR_LEN + {req_q[4:0], 1'b0};
				dec_regrd = 1'b1;
			end
			FC_WR_COIL: begin
				if (req_st >= 16'(SPAN_COIL))
					exc = EXC_ADDR;
				else if (req_q != COIL_ON && req_q != COIL_OFF)
					exc = EXC_VALUE;
				else
					dec_coils[req_st[1:0]] = (req_q == COIL_ON);
			end
			FC_WR_COILS: begin
				exc = range_exc(req_st, req_q, SPAN_COIL);
				if (exc == EXC_NONE && rx_buf_reg[6] != MULTI_BYTES)
					exc = EXC_VALUE;
				for (int i = 0; i < 4; i++) begin
					if (i >= int'(req_st) && i < int'(req_st) + int'(req_q))
						dec_coils[i] = rx_buf_reg[7][3'(i - int'(req_st))];
				end
			end
			default: exc = EXC_FUNC;
		endcase
		if (exc != EXC_NONE) begin
			dec_hdr[1] = fc | EXC_FLAG;
			dec_hdr[2] = exc;
			dec_len = LEN_EXC;
			dec_regrd = 1'b0;
			dec_coils = relay;
		end
	end

	// ==========================================
	// reply sequencer
	logic [7:0] hdr_reg [6];
	logic [7:0] hdr_next [6];
	logic [5:0] len_reg, len_next, idx_reg, idx_next;
	logic regrd_reg, regrd_next;
	logic [4:0] base_reg, base_next;
	logic tx_valid_reg, tx_valid_next;
	logic [7:0] tx_data_reg, tx_data_next;
	logic [15:0] tx_crc_reg, tx_crc_next, tx_crc_step;
	logic [3:0] relay_next;
	logic [5:0] idx_inc, dat_off;
	logic [15:0] word;
	logic [7:0] reply_byte;

	mbs_crc16 u_tx_crc (
		.crc_in(tx_crc_reg),
		.data(tx_data_reg),
		.crc_out(tx_crc_step)
	);

	assign idx_inc = idx_reg + 6'h01;
	assign dat_off = idx_inc - HDR_LEN;
	assign word = reg_word(meas, base_reg + dat_off[5:1]);
	assign reply_byte = (regrd_reg && idx_inc >= HDR_LEN) ?
		(dat_off[0] ? word[7:0] : word[15:8]) : hdr_reg[idx_inc[2:0]];

	always_comb begin
		state_next = state_reg;
		hdr_next = hdr_reg;
		len_next = len_reg;
		idx_next = idx_reg;
		regrd_next = regrd_reg;
		base_next = base_reg;
		tx_valid_next = tx_valid_reg;
		tx_data_next = tx_data_reg;
		tx_crc_next = tx_crc_reg;
		relay_next = relay;
		case (state_reg)
			ST_IDLE: begin
				if (frame_ok) begin
					relay_next = dec_coils;
					hdr_next = dec_hdr;
					len_next = dec_len;
					regrd_next = dec_regrd;
					base_next = req_st[4:0];
					idx_next = 6'h00;
					tx_valid_next = 1'b1;
					tx_data_next = slave_addr;
					tx_crc_next = CRC_INIT;
					state_next = ST_SEND;
				end
			end
			ST_SEND: begin
				if (tx_ready) begin
					tx_crc_next = tx_crc_step;
					if (idx_inc == len_reg) begin
						tx_data_next = tx_crc_step[7:0];
						state_next = ST_CRC_LO;
					end else begin
						idx_next = idx_inc;
						tx_data_next = reply_byte;
					end
				end
			end
			ST_CRC_LO: begin
				if (tx_ready) begin
					tx_data_next = tx_crc_reg[15:8];
					state_next = ST_CRC_HI;
				end
			end
			ST_CRC_HI: begin
				if (tx_ready) begin
					tx_valid_next = 1'b0;
					state_next = ST_IDLE;
				end
			end
			default: begin
				tx_valid_next = 1'b0;
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			hdr_reg <= '{default: 8'h00};
			len_reg <= 6'h00;
			idx_reg <= 6'h00;
			regrd_reg <= 1'b0;
			base_reg <= 5'h00;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
			tx_crc_reg <= CRC_INIT;
			relay <= COILS_RESET;
		end else if (ce) begin
			state_reg <= state_next;
			hdr_reg <= hdr_next;
			len_reg <= len_next;
			idx_reg <= idx_next;
			regrd_reg <= regrd_next;
			base_reg <= base_next;
			tx_valid_reg <= tx_valid_next;
			tx_data_reg <= tx_data_next;
			tx_crc_reg <= tx_crc_next;
			relay <= relay_next;
		end
	end

	assign tx = '{valid: tx_valid_reg, data: tx_data_reg};

	// ==========================================
	// checks
	a_bad_crc_drop: assert property (@(posedge clk) disable iff (reset)
		ce && state_reg == ST_IDLE && rx.frame_end && rx_crc_reg != 16'h0000
		|=> !tx_valid_reg [*3])
		else $error("frame with bad crc answered");
	a_foreign_addr: assert property (@(posedge clk) disable iff (reset)
		ce && state_reg == ST_IDLE && rx.frame_end && rx_buf_reg[0] != slave_addr
		|=> state_reg == ST_IDLE)
		else $error("frame for another address answered");
	a_first_byte: assert property (@(posedge clk) disable iff (reset)
		$rose(tx_valid_reg) |-> tx_data_reg == slave_addr && idx_reg == 6'h00)
		else $error("reply does not open with own address");
	a_crc_order: assert property (@(posedge clk) disable iff (reset)
		ce && state_reg == ST_CRC_LO && tx_ready
		|=> tx_data_reg == tx_crc_reg[15:8] && tx_data_reg == $past(tx_crc_reg[15:8]))
		else $error("crc high byte not after low byte");
	a_multi_write: assert property (@(posedge clk) disable iff (reset)
		ce && frame_ok && fc == FC_WR_COILS && req_st == 16'h0000 && req_q == 16'h0004
		&& rx_buf_reg[6] == MULTI_BYTES |=> relay == $past(rx_buf_reg[7][3:0]))
		else $error("multi relay write not applied");
	a_multi_echo: assert property (@(posedge clk) disable iff (reset)
		ce && frame_ok && fc == FC_WR_COILS && exc == EXC_NONE
		|=> len_reg == LEN_ECHO && {hdr_reg[4], hdr_reg[5]} == $past(req_q))
		else $error("multi write reply lacks quantity");
	a_single_write: assert property (@(posedge clk) disable iff (reset)
		ce && frame_ok && fc == FC_WR_COIL && req_st == 16'h0000 && req_q == COIL_ON
		|=> relay[0] && len_reg == LEN_ECHO)
		else $error("single relay close not applied");
	a_din_reply: assert property (@(posedge clk) disable iff (reset)
		ce && frame_ok && fc == FC_RD_DIN && req_st == 16'h0000 && req_q == 16'h0008
		|=> hdr_reg[2] == 8'h01 && hdr_reg[3] == $past(din_s2_reg) && len_reg == LEN_BITS)
		else $error("discrete input reply wrong");
	a_full_read: assert property (@(posedge clk) disable iff (reset)
		ce && frame_ok && fc == FC_RD_INREG && req_st == 16'h0000 && req_q == 16'h001C
		|=> hdr_reg[2] == 8'h38 && len_reg == 6'h3B)
		else $error("full register read length wrong");
	a_exception: assert property (@(posedge clk) disable iff (reset)
		ce && frame_ok && fc == FC_RD_DIN && req_q == 16'h0009
		|=> hdr_reg[1] == 8'h82 && hdr_reg[2] == EXC_VALUE && len_reg == LEN_EXC)
		else $error("quantity exception missing");

endmodule : mbs_responder

`default_nettype wire

// ---- dv/mbs_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// bus master model: sends requests, collects replies
module mbs_master_model (
	// clock
	input wire logic clk,
	// request bytes
	output var mbs_pkg::mbs_rx_s rx,
	// reply bytes
	input wire mbs_pkg::mbs_tx_s tx,
	output var logic tx_ready
);
	import mbs_pkg::*;

	logic [7:0] got[$];
	bit stall = 1'b0;

	initial begin
		rx = '0;
		tx_ready = 1'b0;
	end

	// byte taken where valid and ready meet at an edge
	always @(posedge clk) begin
		tx_ready <= stall ? ~tx_ready : 1'b1;
		if (tx.valid && tx_ready)
			got.push_back(tx.data);
	end

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc16

	task automatic xfer(input logic [7:0] req[$], input bit slow, input bit bad,
		output logic [7:0] rsp[$]);
		logic [15:0] c;
		int n;
		c = crc16(req) ^ {15'h0000, bad};
		req.push_back(c[7:0]);
		req.push_back(c[15:8]);
		stall = slow;
		got.delete();
		foreach (req[i]) begin
			@(posedge clk);
			rx <= '{1'b1, req[i], 1'b0};
		end
		// idle data differs from the last byte, except in the frame_end cycle, which repeats it
		@(posedge clk);
		rx <= '{1'b0, ~c[15:8], 1'b0};
		@(posedge clk);
		rx <= '{1'b0, c[15:8], 1'b1};
		@(posedge clk);
		rx <= '{1'b0, ~c[15:8], 1'b0};
		n = 0;
		while (n < 400 && !(got.size() > 0 && !tx.valid) && !(got.size() == 0 && n > 40)) begin
			@(negedge clk);
			n++;
		end
		rsp = got;
	endtask : xfer

endmodule : mbs_master_model

`default_nettype wire

// ---- dv/tb_mbs_responder.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// testbench
module tb_mbs_responder;
	import mbs_pkg::*;

	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [7:0] slave_addr = 8'h11;
	logic [7:0] din_pins = 8'hA5;
	mbs_meas_s meas;
	mbs_rx_s rx;
	mbs_tx_s tx;
	logic tx_ready;
	logic [3:0] relay;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] rsp[$];
	logic [7:0] e[$];

	always #20 clk = ~clk;

	mbs_responder mbs_responder_inst (.clk(clk), .reset(reset), .ce(ce),
		.slave_addr(slave_addr), .rx(rx), .tx(tx), .tx_ready(tx_ready),
		.din_pins(din_pins), .meas(meas), .relay(relay));

	mbs_master_model mbs_master_model_inst (.clk(clk), .rx(rx), .tx(tx), .tx_ready(tx_ready));

	// ==========================================
	// helpers
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic ask(input logic [7:0] q[$], input bit slow = 1'b0, input bit bad = 1'b0);
		mbs_master_model_inst.xfer(q, slow, bad, rsp);
	endtask : ask

	task automatic reply_is(input logic [7:0] x[$]);
		logic [15:0] c;
		check("reply length", 16'(rsp.size()), 16'(x.size() + 2));
		if (rsp.size() == x.size() + 2) begin
			foreach (x[i]) check("reply byte", {8'h00, rsp[i]}, {8'h00, x[i]});
			c = mbs_master_model_inst.crc16(x);
			check("reply crc", {rsp[x.size() + 1], rsp[x.size()]}, c);
		end
	endtask : reply_is

	function automatic logic [15:0] exp_reg(input int r);
		if (r <= 11)
			return r[0] ? meas.analog_channel[r / 2][15:0] : meas.analog_channel[r / 2][31:16];
		case (r)
			14: return meas.supply;
			24: return meas.temperature;
			25: return meas.humidity;
			26: return meas.pulse_count[31:16];
			27: return meas.pulse_count[15:0];
			default: return 16'h0000;
		endcase
	endfunction : exp_reg

	// ==========================================
	// scenarios
	task automatic t_multi_write;
		ask('{8'h11, FC_WR_COILS, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'hFA});
		reply_is('{8'h11, FC_WR_COILS, 8'h00, 8'h00, 8'h00, 8'h04});
		check("relay all", relay, 4'hA);
		ask('{8'h11, FC_WR_COILS, 8'h00, 8'h02, 8'h00, 8'h02, 8'h01, 8'h01}, 1'b1);
		reply_is('{8'h11, FC_WR_COILS, 8'h00, 8'h02, 8'h00, 8'h02});
		check("relay partial", relay, 4'h6);
	endtask : t_multi_write

	task automatic t_single_write;
		ask('{8'h11, FC_WR_COIL, 8'h00, 8'h00, 8'hFF, 8'h00});
		reply_is('{8'h11, FC_WR_COIL, 8'h00, 8'h00, 8'hFF, 8'h00});
		check("relay close", relay, 4'h7);
		ask('{8'h11, FC_WR_COIL, 8'h00, 8'h02, 8'h00, 8'h00});
		reply_is('{8'h11, FC_WR_COIL, 8'h00, 8'h02, 8'h00, 8'h00});
		check("relay open", relay, 4'h3);
	endtask : t_single_write

	task automatic t_reads;
		ask('{8'h11, FC_RD_COIL, 8'h00, 8'h01, 8'h00, 8'h03});
		reply_is('{8'h11, FC_RD_COIL, 8'h01, 8'h01});
		ask('{8'h11, FC_RD_DIN, 8'h00, 8'h00, 8'h00, 8'h08});
		reply_is('{8'h11, FC_RD_DIN, 8'h01, 8'hA5});
		ask('{8'h11, FC_RD_DIN, 8'h00, 8'h05, 8'h00, 8'h03});
		reply_is('{8'h11, FC_RD_DIN, 8'h01, 8'h05});
		ask('{8'h11, FC_RD_DIN, 8'h00, 8'h07, 8'h00, 8'h01});
		reply_is('{8'h11, FC_RD_DIN, 8'h01, 8'h01});
	endtask : t_reads

	task automatic t_inreg;
		e = '{8'h11, FC_RD_INREG, 8'h38};
		for (int r = 0; r < 28; r++) begin
			e.push_back(8'(exp_reg(r) >> 8));
			e.push_back(8'(exp_reg(r)));
		end
		ask('{8'h11, FC_RD_INREG, 8'h00, 8'h00, 8'h00, 8'h1C}, 1'b1);
		reply_is(e);
		ask('{8'h11, FC_RD_INREG, 8'h00, 8'h0E, 8'h00, 8'h01});
		reply_is('{8'h11, FC_RD_INREG, 8'h02, 8'h04, 8'hC6});
	endtask : t_inreg

	task automatic t_silent;
		ask('{8'h12, FC_RD_DIN, 8'h00, 8'h00, 8'h00, 8'h08});
		check("other address", 16'(rsp.size()), 16'h0000);
		ask('{8'h11, FC_RD_DIN, 8'h00, 8'h00, 8'h00, 8'h08}, 1'b0, 1'b1);
		check("bad crc", 16'(rsp.size()), 16'h0000);
		@(posedge clk);
		slave_addr <= 8'hF8;
		ask('{8'hF8, FC_RD_DIN, 8'h00, 8'h00, 8'h00, 8'h08});
		check("address out of range", 16'(rsp.size()), 16'h0000);
		@(posedge clk);
		slave_addr <= 8'h11;
	endtask : t_silent

	task automatic t_except;
		ask('{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01});
		reply_is('{8'h11, 8'h83, EXC_FUNC});
		ask('{8'h11, FC_RD_DIN, 8'h00, 8'h00, 8'h00, 8'h09});
		reply_is('{8'h11, 8'h82, EXC_VALUE});
		ask('{8'h11, FC_WR_COIL, 8'h00, 8'h04, 8'hFF, 8'h00});
		reply_is('{8'h11, 8'h85, EXC_ADDR});
		ask('{8'h11, FC_RD_COIL, 8'h00, 8'h03, 8'h00, 8'h02});
		reply_is('{8'h11, 8'h81, EXC_ADDR});
		ask('{8'h11, FC_WR_COIL, 8'h00, 8'h01, 8'h12, 8'h34});
		reply_is('{8'h11, 8'h85, EXC_VALUE});
		ask('{8'h11, FC_WR_COILS, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h0F});
		reply_is('{8'h11, 8'h8F, EXC_VALUE});
		check("relay kept", relay, 4'h3);
	endtask : t_except

	// ==========================================
	// main sequence and timeout
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		meas = '0;
		for (int i = 0; i < 6; i++)
			meas.analog_channel[i] = {16'hA000 + 16'(i), 16'h0B00 + 16'(i)};
		meas.supply = 16'h04C6;
		meas.temperature = 16'h0B36;
		meas.humidity = 16'h1BE4;
		meas.pulse_count = 32'h0001_000B;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check("relay at reset", relay, 4'h0);
		check("tx idle at reset", {15'h0000, tx.valid}, 16'h0000);
		t_multi_write();
		t_single_write();
		t_reads();
		t_inreg();
		t_silent();
		t_except();
		end_of_test();
	end

endmodule : tb_mbs_responder

`default_nettype wire
